// *** core/cssw_pkg.sv ***
// constants, types and state record of the clock source switcher
package cssw_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [13:0] CTRL_IDX  = 14'h0742;
    localparam logic [15:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
    localparam logic [15:0] STAT_ADDR = CTRL_ADDR + 16'h0004;
    localparam int CUR_LSB    = 12;
    localparam int NXT_LSB    = 8;
    localparam int FREEZE_BIT = 7;
    localparam int LOCK_BIT   = 5;
    localparam int CF_BIT     = 3;
    localparam int KEEP_BIT   = 1;
    localparam int SWREQ_BIT  = 0;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_OSC_LSB  = 4;
    localparam int ST_PLL_BIT  = 8;
    // ------------------------------------------------------------
    // unlock keys
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_HI1 = 8'h78;
    localparam logic [7:0] KEY_HI2 = 8'h9a;
    localparam logic [7:0] KEY_LO1 = 8'h46;
    localparam logic [7:0] KEY_LO2 = 8'h57;
    // ------------------------------------------------------------
    // sources, oscillators, modes, timing
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_FRC     = 3'h0;
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI     = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_SEC     = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_RC_OSC    = 3'h5;
    localparam logic [2:0] SRC_FRC_DIV = 3'h7;
    localparam int OSC_FRC  = 0;
    localparam int OSC_PRI  = 1;
    localparam int OSC_SEC  = 2;
    localparam int OSC_LOW_POWER_RC_OSC = 3;
    localparam logic [1:0] MODE_SW_ONLY = 2'h1;
    localparam int OST_CYCLES_DEF = 1024;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_WAIT_OSC, ST_WAIT_PLL, ST_SWAP} cssw_st_t;
    typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_OPEN} cssw_ul_t;
    typedef struct packed {
        cssw_st_t    st;
        cssw_ul_t    uhi;
        cssw_ul_t    ulo;
        logic [2:0]  cur;
        logic [2:0]  nxt;
        logic        swreq;
        logic        cf;
        logic        lock;
        logic        freeze;
        logic        keep_on;
        logic [1:0]  mode;
        logic        boot;
        logic [15:0] cnt;
        logic [3:0]  osc_en;
        logic        pll;
        logic        rdy;
        logic        err;
        logic [31:0] rdata;
    } cssw_state_t;
    localparam cssw_state_t STATE_RST = '{st: ST_IDLE, uhi: UL_IDLE, ulo: UL_IDLE,
                                          cur: SRC_FRC, boot: 1'b1, default: '0};
endpackage : cssw_pkg

// *** core/cssw_switcher.sv ***
// clock source switcher: apb control register, unlock, switch sequencer
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cssw_switcher #(
    parameter int OST_CYCLES = cssw_pkg::OST_CYCLES_DEF
) (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [15:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [2:0]  STRAP_SRC,
    input  wire logic [1:0]  STRAP_MODE,
    input  wire logic        STRAP_TWO_SPEED,
    input  wire logic        WDT_EN,
    input  wire logic [3:0]  OSC_OK,
    input  wire logic        PLL_LOCKED,
    input  wire logic        CLK_FAIL,
    input  wire logic        SLEEP_REQ,
    output logic      [3:0]  OSC_EN,
    output logic             PLL_EN,
    output logic      [2:0]  SYS_SEL
);
    // ------------------------------------------------------------
    // source decoding
    // ------------------------------------------------------------
    function automatic logic [3:0] src_osc(input logic [2:0] src);
        logic [3:0] oh;
        oh = 4'h0;
        case (src)
            cssw_pkg::SRC_FRC, cssw_pkg::SRC_FRC_PLL,
            cssw_pkg::SRC_FRC_DIV: oh[cssw_pkg::OSC_FRC] = 1'b1;
            cssw_pkg::SRC_PRI, cssw_pkg::SRC_PRI_PLL: oh[cssw_pkg::OSC_PRI] = 1'b1;
            cssw_pkg::SRC_SEC:  oh[cssw_pkg::OSC_SEC] = 1'b1;
            cssw_pkg::SRC_LOW_POWER_RC_OSC: oh[cssw_pkg::OSC_LOW_POWER_RC_OSC] = 1'b1;
            default: oh = 4'h0;
        endcase
        return oh;
    endfunction : src_osc

    function automatic logic src_pll(input logic [2:0] src);
        return (src == cssw_pkg::SRC_FRC_PLL) || (src == cssw_pkg::SRC_PRI_PLL);
    endfunction : src_pll

    function automatic logic src_xtal(input logic [2:0] src);
        logic [3:0] oh;
        oh = src_osc(src);
        return oh[cssw_pkg::OSC_PRI] | oh[cssw_pkg::OSC_SEC];
    endfunction : src_xtal

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cssw_pkg::cssw_state_t s_q;
    cssw_pkg::cssw_state_t s_d;
    logic       acc;
    logic       hit_ctrl;
    logic       hit_stat;
    logic       hi_w;
    logic       lo_w;
    logic       sw_en;
    logic       fsm_on;
    logic       allowed;
    logic       req_set;
    logic       req_clr;
    logic       fail_hit;
    logic       tgt_ok;
    logic [3:0] keep;

    always_comb begin
        s_d      = s_q;
        hit_ctrl = (PADDR == cssw_pkg::CTRL_ADDR);
        hit_stat = (PADDR == cssw_pkg::STAT_ADDR);
        acc      = PSEL & PENABLE & s_q.rdy;
        hi_w     = acc & PWRITE & hit_ctrl & PSTRB[1];
        lo_w     = acc & PWRITE & hit_ctrl & PSTRB[0];
        sw_en    = ~s_q.mode[1];
        fsm_on   = sw_en & ~s_q.mode[0];
        allowed  = sw_en & ~(s_q.freeze & (s_q.mode == cssw_pkg::MODE_SW_ONLY));
        req_set  = 1'b0;
        req_clr  = 1'b0;
        fail_hit = CLK_FAIL & fsm_on;
        tgt_ok   = |(src_osc(s_q.nxt) & OSC_OK);
        keep     = 4'h0;

        // --------------------------------------------------------
        // apb slave: one wait state, registered answer
        // --------------------------------------------------------
        s_d.rdy = PSEL & PENABLE & ~s_q.rdy;
        s_d.err = s_d.rdy & ~(hit_ctrl | hit_stat);
        s_d.rdata = 32'h0;
        if (s_d.rdy && !PWRITE && hit_ctrl) begin
            s_d.rdata[cssw_pkg::CUR_LSB +: 3] = s_q.cur;
            s_d.rdata[cssw_pkg::NXT_LSB +: 3] = s_q.nxt;
            s_d.rdata[cssw_pkg::FREEZE_BIT]   = s_q.freeze;
            s_d.rdata[cssw_pkg::LOCK_BIT]     = s_q.lock;
            s_d.rdata[cssw_pkg::CF_BIT]       = s_q.cf;
            s_d.rdata[cssw_pkg::KEEP_BIT]     = s_q.keep_on;
            s_d.rdata[cssw_pkg::SWREQ_BIT]    = s_q.swreq;
        end else if (s_d.rdy && !PWRITE && hit_stat) begin
            s_d.rdata[1:0]                      = s_q.mode;
            s_d.rdata[cssw_pkg::ST_BUSY_BIT]    = (s_q.st != cssw_pkg::ST_IDLE);
            s_d.rdata[cssw_pkg::ST_OSC_LSB +: 4] = s_q.osc_en;
            s_d.rdata[cssw_pkg::ST_PLL_BIT]     = s_q.pll;
        end

        // --------------------------------------------------------
        // unlock sequences, one each for byte lanes 1 and 0
        // --------------------------------------------------------
        if (acc) begin
            if (s_q.uhi == cssw_pkg::UL_OPEN) begin
                s_d.uhi = cssw_pkg::UL_IDLE;
                if (hi_w && s_q.st == cssw_pkg::ST_IDLE) begin
                    s_d.nxt = PWDATA[cssw_pkg::NXT_LSB +: 3];
                end
            end else if (s_q.uhi == cssw_pkg::UL_KEY1 && hi_w
                         && PWDATA[15:8] == cssw_pkg::KEY_HI2) begin
                s_d.uhi = cssw_pkg::UL_OPEN;
            end else if (hi_w && PWDATA[15:8] == cssw_pkg::KEY_HI1) begin
                s_d.uhi = cssw_pkg::UL_KEY1;
            end else begin
                s_d.uhi = cssw_pkg::UL_IDLE;
            end
            if (s_q.ulo == cssw_pkg::UL_OPEN) begin
                s_d.ulo = cssw_pkg::UL_IDLE;
                if (lo_w) begin
                    s_d.freeze = s_q.freeze | PWDATA[cssw_pkg::FREEZE_BIT];
                    s_d.keep_on = PWDATA[cssw_pkg::KEEP_BIT];
                    if (!PWDATA[cssw_pkg::CF_BIT]) begin
                        s_d.cf = 1'b0;
                    end
                    req_set = PWDATA[cssw_pkg::SWREQ_BIT] & allowed;
                    req_clr = ~PWDATA[cssw_pkg::SWREQ_BIT] & s_q.swreq;
                end
            end else if (s_q.ulo == cssw_pkg::UL_KEY1 && lo_w
                         && PWDATA[7:0] == cssw_pkg::KEY_LO2) begin
                s_d.ulo = cssw_pkg::UL_OPEN;
            end else if (lo_w && PWDATA[7:0] == cssw_pkg::KEY_LO1) begin
                s_d.ulo = cssw_pkg::UL_KEY1;
            end else begin
                s_d.ulo = cssw_pkg::UL_IDLE;
            end
        end

        // --------------------------------------------------------
        // switch sequencer
        // --------------------------------------------------------
        if (s_q.boot) begin
            s_d.boot = 1'b0;
            s_d.mode = STRAP_MODE;
            if (STRAP_TWO_SPEED && STRAP_SRC != cssw_pkg::SRC_FRC) begin
                s_d.nxt   = STRAP_SRC;
                s_d.swreq = 1'b1;
                s_d.st    = cssw_pkg::ST_START;
            end else begin
                s_d.cur = STRAP_SRC;
                s_d.nxt = STRAP_SRC;
            end
        end else if (req_clr) begin
            s_d.swreq = 1'b0;
            s_d.st    = cssw_pkg::ST_IDLE;
            s_d.cnt   = 16'h0;
        end else if (req_set) begin
            if (s_q.nxt == s_q.cur) begin
                s_d.swreq = 1'b0;
                s_d.st    = cssw_pkg::ST_IDLE;
            end else begin
                s_d.swreq = 1'b1;
                s_d.st    = cssw_pkg::ST_START;
                s_d.cf    = 1'b0;
            end
        end else begin
            case (s_q.st)
                cssw_pkg::ST_IDLE: begin
                    s_d.cnt = 16'h0;
                end
                cssw_pkg::ST_START: begin
                    s_d.cnt = 16'h0;
                    s_d.st  = cssw_pkg::ST_WAIT_OSC;
                end
                cssw_pkg::ST_WAIT_OSC: begin
                    if (!tgt_ok) begin
                        s_d.cnt = 16'h0;
                    end else if (src_xtal(s_q.nxt)
                                 && s_q.cnt != 16'(OST_CYCLES - 1)) begin
                        s_d.cnt = s_q.cnt + 16'h1;
                    end else if (src_pll(s_q.nxt)) begin
                        s_d.st = cssw_pkg::ST_WAIT_PLL;
                    end else begin
                        s_d.st = cssw_pkg::ST_SWAP;
                    end
                end
                cssw_pkg::ST_WAIT_PLL: begin
                    if (s_q.lock && PLL_LOCKED) begin
                        s_d.st = cssw_pkg::ST_SWAP;
                    end
                end
                cssw_pkg::ST_SWAP: begin
                    s_d.cur   = s_q.nxt;
                    s_d.swreq = 1'b0;
                    s_d.st    = cssw_pkg::ST_IDLE;
                end
                default: begin
                    s_d.st = cssw_pkg::ST_IDLE;
                end
            endcase
        end

        if (SLEEP_REQ && s_q.st != cssw_pkg::ST_IDLE) begin
            s_d.st    = cssw_pkg::ST_IDLE;
            s_d.swreq = 1'b0;
            s_d.cur   = s_q.cur;
            s_d.cnt   = 16'h0;
        end
        if (fail_hit) begin
            s_d.cur   = cssw_pkg::SRC_FRC;
            s_d.cf    = 1'b1;
            s_d.swreq = 1'b0;
            s_d.st    = cssw_pkg::ST_IDLE;
            s_d.cnt   = 16'h0;
        end

        // --------------------------------------------------------
        // oscillator and pll enables, lock status
        // --------------------------------------------------------
        keep[cssw_pkg::OSC_LOW_POWER_RC_OSC] = WDT_EN | fsm_on;
        keep[cssw_pkg::OSC_SEC]  = s_d.keep_on;
        s_d.osc_en = src_osc(s_d.cur) | keep;
        if (s_d.st != cssw_pkg::ST_IDLE) begin
            s_d.osc_en = s_d.osc_en | src_osc(s_d.nxt);
        end
        s_d.pll = src_pll(s_d.cur)
                  | (src_pll(s_d.nxt) && (s_d.st == cssw_pkg::ST_WAIT_PLL
                                          || s_d.st == cssw_pkg::ST_SWAP));
        if (s_d.st == cssw_pkg::ST_START) begin
            s_d.lock = 1'b0;
        end else begin
            s_d.lock = PLL_LOCKED & s_q.pll;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            s_q <= cssw_pkg::STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign PRDATA  = s_q.rdata;
    assign PREADY  = s_q.rdy;
    assign PSLVERR = s_q.err;
    assign OSC_EN  = s_q.osc_en;
    assign PLL_EN  = s_q.pll;
    assign SYS_SEL = s_q.cur;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    localparam int OST_LAST = OST_CYCLES - 1;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    sequence seq_swap;
        s_q.st == cssw_pkg::ST_SWAP && !fail_hit && !SLEEP_REQ && !req_set && !req_clr;
    endsequence
    sequence seq_done;
        s_q.st == cssw_pkg::ST_IDLE && !s_q.swreq;
    endsequence

    a_start_clears: assert property (s_q.st == cssw_pkg::ST_START |-> !s_q.lock && !s_q.cf)
        else $error("switch start left lock or fail flag set");
    a_swap_commit: assert property (seq_swap |=> seq_done ##0 s_q.cur == $past(s_q.nxt))
        else $error("switch completion did not copy source or clear request");
    a_make_break: assert property (s_q.st == cssw_pkg::ST_SWAP |-> (s_q.osc_en & src_osc(s_q.nxt)) == src_osc(s_q.nxt))
        else $error("new source not enabled at swap");
    a_nxt_protect: assert property (s_q.st != cssw_pkg::ST_IDLE |=> s_q.nxt == $past(s_q.nxt))
        else $error("next source changed during a switch");
    a_freeze_entry: assert property ($rose(s_q.freeze) |-> $past(s_q.ulo) == cssw_pkg::UL_OPEN && $past(acc))
        else $error("freeze set without an open unlock window");
    a_freeze_sticky: assert property (s_q.freeze |=> s_q.freeze)
        else $error("freeze bit cleared");
    a_sleep_abort: assert property (SLEEP_REQ && !fail_hit && s_q.st != cssw_pkg::ST_IDLE |=> seq_done ##0 $stable(s_q.cur))
        else $error("sleep did not abort the switch");
    a_fail_switch: assert property (fail_hit |=> s_q.cur == cssw_pkg::SRC_FRC && s_q.cf && !s_q.swreq)
        else $error("fail switch did not load fast rc");
    a_pll_wait: assert property (s_q.st == cssw_pkg::ST_SWAP && src_pll(s_q.nxt) |-> s_q.lock && $past(s_q.lock))
        else $error("pll switch without lock");
    a_ost_wait: assert property ($past(s_q.st) == cssw_pkg::ST_WAIT_OSC
        && s_q.st != cssw_pkg::ST_WAIT_OSC && s_q.st != cssw_pkg::ST_IDLE
        && s_q.st != cssw_pkg::ST_START && src_xtal(s_q.nxt)
        |-> $past(s_q.cnt) == 16'(OST_LAST))
        else $error("crystal switch before startup timer expired");
    a_redundant: assert property (req_set && s_q.nxt == s_q.cur && !fail_hit && !SLEEP_REQ |=> seq_done)
        else $error("redundant request not dropped");
endmodule : cssw_switcher
`default_nettype wire

// *** tb/cssw_testbench.sv ***
// self-checking bench of the clock source switcher
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %0t %s", $time, m); end end
module testbench;
    logic        clk       = 1'h0;
    logic        resetn    = 1'h0;
    logic        psel      = 1'h0;
    logic        penable   = 1'h0;
    logic        pwrite    = 1'h0;
    logic [15:0] paddr     = 16'h0;
    logic [31:0] pwdata    = 32'h0;
    logic [3:0]  pstrb     = 4'h0;
    logic [1:0]  strap_mode = cssw_pkg::MODE_SW_ONLY;
    logic [3:0]  osc_ok    = 4'hd;
    logic        sleep_req = 1'h0;
    logic        pll_locked = 1'h0;
    logic        clk_fail  = 1'h0;
    logic        pll_en;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  osc_en;
    logic [2:0]  sys_sel;
    logic [31:0] rv;
    logic        errv;
    int          comparisons = 0;
    int          n_mismatch  = 0;

    always #12.5 clk = ~clk;

    cssw_switcher #(.OST_CYCLES(8)) cssw_switcher_inst (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .STRAP_SRC(3'h0), .STRAP_MODE(strap_mode),
        .STRAP_TWO_SPEED(1'h0), .WDT_EN(1'h0), .OSC_OK(osc_ok), .PLL_LOCKED(pll_locked),
        .CLK_FAIL(clk_fail), .SLEEP_REQ(sleep_req), .OSC_EN(osc_en), .PLL_EN(pll_en),
        .SYS_SEL(sys_sel));

    // ------------------------------------------------------------
    // closing report
    // ------------------------------------------------------------
    task automatic final_report();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // apb master and register helpers
    // ------------------------------------------------------------
    // one idle edge first so a new setup never lands in the release step
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        int i;
        @(posedge clk);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'h1;
        for (i = 0; i < 16 && pready !== 1'h1; i++) begin
            @(posedge clk);
        end
        if (i == 16) begin
            `CHK(1'h0, 1'h1, "apb answer timeout")
            final_report();
        end
        rv      = prdata;
        errv    = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : xfer

    task automatic wr(input logic [31:0] d, input logic [3:0] s);
        xfer(1'h1, cssw_pkg::CTRL_ADDR, d, s);
    endtask : wr

    task automatic rd();
        xfer(1'h0, cssw_pkg::CTRL_ADDR, 32'h0, 4'h0);
    endtask : rd

    task automatic set_next(input logic [2:0] n);
        wr({16'h0, cssw_pkg::KEY_HI1, 8'h0}, 4'h2);
        wr({16'h0, cssw_pkg::KEY_HI2, 8'h0}, 4'h2);
        wr({21'h0, n, 8'h0}, 4'h2);
    endtask : set_next

    task automatic set_low(input logic [7:0] v);
        wr({24'h0, cssw_pkg::KEY_LO1}, 4'h1);
        wr({24'h0, cssw_pkg::KEY_LO2}, 4'h1);
        wr({24'h0, v}, 4'h1);
    endtask : set_low

    task automatic wait_done();
        int i;
        for (i = 0; i < 40; i++) begin
            rd();
            if (rv[cssw_pkg::SWREQ_BIT] === 1'h0) break;
        end
        `CHK(rv[0], 1'h0, "switch never finished")
        if (rv[0] !== 1'h0) begin
            final_report();
        end
    endtask : wait_done

    // mid-run reset with a new switch mode strap
    task automatic restart(input logic [1:0] m);
        resetn     <= 1'h0;
        strap_mode <= m;
        repeat (4) @(posedge clk);
        resetn     <= 1'h1;
    endtask : restart

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_switch();
        rd();
        `CHK(rv[15:0], 16'h0, "ctrl after reset")
        set_next(cssw_pkg::SRC_LOW_POWER_RC_OSC);
        set_low(8'h01);
        wait_done();
        `CHK(sys_sel, cssw_pkg::SRC_LOW_POWER_RC_OSC, "not on low_power_rc_osc")
        `CHK(rv[14:12], cssw_pkg::SRC_LOW_POWER_RC_OSC, "current not copied")
        `CHK(osc_en, 4'h8, "old source left on")
        set_low(8'h01);
        rd();
        `CHK(rv[0], 1'h0, "redundant request kept")
        $display("test switch done");
    endtask : t_switch

    task automatic t_unlock();
        wr({16'h0, cssw_pkg::KEY_HI1, 8'h0}, 4'h2);
        rd();
        wr({16'h0, cssw_pkg::KEY_HI2, 8'h0}, 4'h2);
        wr(32'h0, 4'h2);
        rd();
        `CHK(rv[10:8], cssw_pkg::SRC_LOW_POWER_RC_OSC, "broken unlock accepted")
        wr({16'h0, cssw_pkg::KEY_HI1, 8'h0}, 4'h2);
        wr({16'h0, cssw_pkg::KEY_HI2, 8'h0}, 4'h2);
        rd();
        wr(32'h0, 4'h2);
        rd();
        `CHK(rv[10:8], cssw_pkg::SRC_LOW_POWER_RC_OSC, "late write accepted")
        $display("test unlock done");
    endtask : t_unlock

    task automatic t_absent();
        set_next(cssw_pkg::SRC_PRI);
        set_low(8'h01);
        repeat (40) @(posedge clk);
        set_next(cssw_pkg::SRC_FRC);
        rd();
        `CHK(rv[0], 1'h1, "request dropped without source")
        `CHK(rv[10:8], cssw_pkg::SRC_PRI, "write while busy taken")
        `CHK(osc_en[1], 1'h1, "target not turned on")
        `CHK(sys_sel, cssw_pkg::SRC_LOW_POWER_RC_OSC, "left current source")
        set_low(8'h00);
        rd();
        `CHK(rv[0], 1'h0, "abort ignored")
        `CHK(sys_sel, cssw_pkg::SRC_LOW_POWER_RC_OSC, "abort moved source")
        set_low(8'h01);
        sleep_req <= 1'h1;
        @(posedge clk);
        sleep_req <= 1'h0;
        rd();
        `CHK(rv[0], 1'h0, "sleep did not abort")
        `CHK(rv[14:12], cssw_pkg::SRC_LOW_POWER_RC_OSC, "sleep changed source")
        $display("test absent done");
    endtask : t_absent

    task automatic t_crystal();
        set_next(cssw_pkg::SRC_SEC);
        set_low(8'h01);
        rd();
        rd();
        `CHK(rv[0], 1'h1, "startup timer skipped")
        wait_done();
        `CHK(sys_sel, cssw_pkg::SRC_SEC, "not on secondary")
        `CHK(osc_en, 4'h4, "low_power_rc_osc left on")
        xfer(1'h1, 16'h0100, 32'h0, 4'hf);
        `CHK(errv, 1'h1, "unmapped not refused")
        xfer(1'h0, cssw_pkg::STAT_ADDR, 32'h0, 4'h0);
        `CHK(errv, 1'h0, "status refused")
        `CHK(rv[1:0], cssw_pkg::MODE_SW_ONLY, "mode readback")
        $display("test crystal done");
    endtask : t_crystal

    task automatic t_pll();
        set_next(cssw_pkg::SRC_FRC_PLL); // pll target, switched to from the secondary non-pll source
        set_low(8'h01);
        repeat (10) @(posedge clk);
        rd();
        `CHK(rv[0], 1'h1, "pll switch without lock")
        `CHK(rv[5], 1'h0, "lock shown without pll lock")
        `CHK(pll_en, 1'h1, "pll not started")
        set_low(8'h00);
        rd();
        `CHK(pll_en, 1'h0, "pll left on after abort")
        set_low(8'h01);
        pll_locked <= 1'h1;
        wait_done();
        `CHK(sys_sel, cssw_pkg::SRC_FRC_PLL, "not on fast rc pll")
        `CHK(osc_en, 4'h1, "secondary left on")
        rd();
        `CHK(rv[5], 1'h1, "lock bit not following")
        $display("test pll done");
    endtask : t_pll

    task automatic t_freeze();
        set_low(8'h80);
        set_next(cssw_pkg::SRC_FRC);
        set_low(8'h01);
        rd();
        `CHK(rv[0], 1'h0, "switch despite freeze")
        `CHK(sys_sel, cssw_pkg::SRC_FRC_PLL, "frozen source moved")
        set_low(8'h00);
        rd();
        `CHK(rv[7], 1'h1, "freeze cleared")
        $display("test freeze done");
    endtask : t_freeze

    task automatic t_fail();
        restart(2'h0);
        xfer(1'h0, cssw_pkg::STAT_ADDR, 32'h0, 4'h0);
        `CHK(rv[1:0], 2'h0, "monitor mode not taken")
        `CHK(osc_en, 4'h9, "low_power_rc_osc not kept for monitor")
        set_next(cssw_pkg::SRC_SEC);
        set_low(8'h01);
        wait_done();
        `CHK(osc_en, 4'hc, "low_power_rc_osc dropped with monitor on")
        set_next(cssw_pkg::SRC_PRI);
        set_low(8'h01);
        clk_fail <= 1'h1;
        @(posedge clk);
        clk_fail <= 1'h0;
        rd();
        `CHK(rv[14:12], cssw_pkg::SRC_FRC, "current not fast rc")
        `CHK(rv[3], 1'h1, "fail flag not set")
        `CHK(rv[0], 1'h0, "pending switch kept")
        `CHK(sys_sel, cssw_pkg::SRC_FRC, "not back on fast rc")
        $display("test fail done");
    endtask : t_fail

    task automatic t_nosw();
        restart(2'h2);
        set_next(cssw_pkg::SRC_SEC);
        set_low(8'h01);
        clk_fail <= 1'h1;
        @(posedge clk);
        clk_fail <= 1'h0;
        rd();
        `CHK(rv[0], 1'h0, "request taken while disabled")
        `CHK(rv[3], 1'h0, "fail acted on while disabled")
        `CHK(sys_sel, cssw_pkg::SRC_FRC, "source moved while disabled")
        $display("test no switch done");
    endtask : t_nosw

    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'h1;
        t_switch();
        t_unlock();
        t_absent();
        t_crystal();
        t_pll();
        t_freeze();
        t_fail();
        t_nosw();
        final_report();
    end
endmodule : testbench
`default_nettype wire
